//--- logic/frequency_ramp_generator.sv
// How it works
// [RULE1] No ramping unless ramp enable is set
// [RULE2] Mode bit selects automatic or pin ramping
// [RULE3] Add increment to numerator every active cycle
// [RULE4] Length field sets segment duration in cycles
// [RULE5] Recalibrate when numerator drifts past threshold
// [RULE6] Calibrate-on-ramp requests calibration each segment start
// [RULE7] Software sets denominator maximum; effective two-to-24
// [RULE8] Software keeps lock detect delay at zero
// [RULE9] Clamp numerator between low and high limits
// [RULE10] Two preset segments alternate without software help
// [RULE11] Pin ramping needs enable and manual both set
// [RULE12] Pin edges synchronised into local clock first
// [RULE13] Pin edges during calibration are dropped
// [RULE14] Controller keeps pin clock slow, direction apart
// [RULE15] Direction low adds first, high second increment
// [RULE16] Phase detector not slower than calibration clock
// [RULE17] Phase detector rate kept at 125 MHz; hclk here runs at 250 MHz
// [RULE18] Increments are signed 30-bit values
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module frequency_ramp_generator #(
    parameter int NUM_W = ramp_pkg::NUM_W
) (
    input wire logic hclk, // Phase detector clock, 250 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic ramp_clock_pin, // External ramp clock
    input wire logic ramp_direction_pin, // External direction
    input wire logic cal_busy, // VCO calibration in progress
    output logic cal_request, // One-cycle calibration request
    output logic [NUM_W-1:0] frac_numerator // Ramped numerator
);
    // Sums are kept two bits wider than the numerator, so the width must stay below 64
    if (NUM_W <= 32 || NUM_W > 63) begin : g_num_w_check
        $error("NUM_W must be 33..63");
    end

    localparam int IW = ramp_pkg::INC_W;
    localparam int LW = ramp_pkg::LEN_W;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN} ramp_state_t;

    ramp_pin_if pins ();

    ramp_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ramp_clock_pin(ramp_clock_pin),
        .ramp_direction_pin(ramp_direction_pin),
        .pins(pins)
    );

    function automatic logic signed [NUM_W:0] sext_inc(input logic [IW-1:0] v);
        sext_inc = {{(NUM_W+1-IW){v[IW-1]}}, v}; // [RULE18]
    endfunction : sext_inc

    function automatic logic signed [NUM_W:0] sext_num(input logic [NUM_W-1:0] v);
        sext_num = {v[NUM_W-1], v};
    endfunction : sext_num

    // Register file
    logic [2:0] ctrl_q, ctrl_d;
    logic [IW-1:0] inc0_q, inc0_d, inc1_q, inc1_d;
    logic [LW-1:0] len0_q, len0_d, len1_q, len1_d;
    logic [NUM_W-1:0] thr_q, thr_d, liml_q, liml_d, limh_q, limh_d, stnum_q, stnum_d;
    logic start_q, start_d;
    logic wr_q, wr_d;
    logic [ramp_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [ramp_pkg::ADDR_W-1:0] a_addr;
    logic a_valid;

    // Ramp engine
    ramp_state_t state_q, state_d;
    logic seg_q, seg_d;
    logic [LW-1:0] cnt_q, cnt_d;
    logic [NUM_W-1:0] num_q, num_d, lastcal_q, lastcal_d;
    logic calreq_q, calreq_d;
    logic clamped_q, clamped_d;

    logic ramp_en, manual, trig_cal, man_active, cal_block, step;
    logic [IW-1:0] inc_sel;
    logic [LW-1:0] len_sel;
    logic signed [NUM_W+1:0] raw_sum, drift;
    logic signed [NUM_W:0] sum_c;
    logic signed [NUM_W:0] num_x, inc_x;
    logic [NUM_W+1:0] drift_mag;
    logic over_thr, seg_start, sum_clamped;

    assign ramp_en = ctrl_q[ramp_pkg::CTRL_EN_BIT];
    assign manual = ctrl_q[ramp_pkg::CTRL_MANUAL_BIT];
    assign trig_cal = ctrl_q[ramp_pkg::CTRL_TRIGCAL_BIT];
    assign man_active = ramp_en & manual; // [RULE11]
    // Calibration counts as busy from the request cycle on
    assign cal_block = cal_busy | calreq_q;
    assign a_valid = hsel & hready & (htrans == ramp_pkg::HTRANS_NONSEQ);
    assign a_addr = {haddr[ramp_pkg::ADDR_W-1:2], 2'b00};

    always_comb begin
        ctrl_d = ctrl_q;
        inc0_d = inc0_q;
        inc1_d = inc1_q;
        len0_d = len0_q;
        len1_d = len1_q;
        thr_d = thr_q;
        liml_d = liml_q;
        limh_d = limh_q;
        stnum_d = stnum_q;
        start_d = 1'b0;
        wr_d = a_valid & hwrite;
        addr_d = a_addr;
        rdata_d = 32'h00000000;
        if (wr_q) begin
            case (addr_q)
                ramp_pkg::OFS_CTRL: begin
                    ctrl_d = hwdata[2:0];
                    start_d = hwdata[ramp_pkg::CTRL_START_BIT];
                end
                ramp_pkg::OFS_INC0: inc0_d = hwdata[IW-1:0];
                ramp_pkg::OFS_INC1: inc1_d = hwdata[IW-1:0];
                ramp_pkg::OFS_LEN0: len0_d = hwdata[LW-1:0];
                ramp_pkg::OFS_LEN1: len1_d = hwdata[LW-1:0];
                ramp_pkg::OFS_THR_LO: thr_d[31:0] = hwdata;
                ramp_pkg::OFS_THR_HI: thr_d[NUM_W-1:32] = hwdata[NUM_W-33:0];
                ramp_pkg::OFS_LIML_LO: liml_d[31:0] = hwdata;
                ramp_pkg::OFS_LIML_HI: liml_d[NUM_W-1:32] = hwdata[NUM_W-33:0];
                ramp_pkg::OFS_LIMH_LO: limh_d[31:0] = hwdata;
                ramp_pkg::OFS_LIMH_HI: limh_d[NUM_W-1:32] = hwdata[NUM_W-33:0];
                ramp_pkg::OFS_STNUM_LO: stnum_d[31:0] = hwdata;
                ramp_pkg::OFS_STNUM_HI: stnum_d[NUM_W-1:32] = hwdata[NUM_W-33:0];
                default: ;
            endcase
        end
        if (a_valid && !hwrite) begin
            case (a_addr)
                ramp_pkg::OFS_CTRL: rdata_d = {29'h00000000, ctrl_q};
                ramp_pkg::OFS_INC0: rdata_d = {2'h0, inc0_q};
                ramp_pkg::OFS_INC1: rdata_d = {2'h0, inc1_q};
                ramp_pkg::OFS_LEN0: rdata_d = {16'h0000, len0_q};
                ramp_pkg::OFS_LEN1: rdata_d = {16'h0000, len1_q};
                ramp_pkg::OFS_THR_LO: rdata_d = thr_q[31:0];
                ramp_pkg::OFS_THR_HI: rdata_d = 32'(thr_q[NUM_W-1:32]);
                ramp_pkg::OFS_LIML_LO: rdata_d = liml_q[31:0];
                ramp_pkg::OFS_LIML_HI: rdata_d = 32'(liml_q[NUM_W-1:32]);
                ramp_pkg::OFS_LIMH_LO: rdata_d = limh_q[31:0];
                ramp_pkg::OFS_LIMH_HI: rdata_d = 32'(limh_q[NUM_W-1:32]);
                ramp_pkg::OFS_STNUM_LO: rdata_d = stnum_q[31:0];
                ramp_pkg::OFS_STNUM_HI: rdata_d = 32'(stnum_q[NUM_W-1:32]);
                ramp_pkg::OFS_STATUS: rdata_d = {28'h0000000, clamped_q, cal_block,
                                                 seg_q, state_q == ST_RUN};
                ramp_pkg::OFS_NUM_LO: rdata_d = num_q[31:0];
                ramp_pkg::OFS_NUM_HI: rdata_d = 32'(num_q[NUM_W-1:32]);
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= ramp_pkg::CTRL_RESET;
            inc0_q <= ramp_pkg::INC_RESET;
            inc1_q <= ramp_pkg::INC_RESET;
            len0_q <= ramp_pkg::LEN_RESET;
            len1_q <= ramp_pkg::LEN_RESET;
            thr_q <= NUM_W'(ramp_pkg::THR_RESET);
            liml_q <= NUM_W'(ramp_pkg::LIML_RESET);
            limh_q <= NUM_W'(ramp_pkg::LIMH_RESET);
            stnum_q <= NUM_W'(ramp_pkg::NUM_RESET);
            start_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            inc0_q <= inc0_d;
            inc1_q <= inc1_d;
            len0_q <= len0_d;
            len1_q <= len1_d;
            thr_q <= thr_d;
            liml_q <= liml_d;
            limh_q <= limh_d;
            stnum_q <= stnum_d;
            start_q <= start_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        if (manual) begin
            inc_sel = pins.dir ? inc1_q : inc0_q; // [RULE15]
        end else begin
            inc_sel = seg_q ? inc1_q : inc0_q;
        end
        len_sel = seg_q ? len1_q : len0_q;
        num_x = sext_num(num_q);
        inc_x = sext_inc(inc_sel); // [RULE18]
        raw_sum = {num_x[NUM_W], num_x} + {inc_x[NUM_W], inc_x}; // [RULE3]
        sum_clamped = 1'b1;
        // Compare two bits wider so an overflowing sum still clamps the right way
        // Concatenations are unsigned, so the limits are cast to keep the compare signed
        if (raw_sum < $signed({{2{liml_q[NUM_W-1]}}, liml_q})) begin
            sum_c = sext_num(liml_q); // [RULE9]
        end else if (raw_sum > $signed({{2{limh_q[NUM_W-1]}}, limh_q})) begin
            sum_c = sext_num(limh_q); // [RULE9]
        end else begin
            sum_c = raw_sum[NUM_W:0];
            sum_clamped = 1'b0;
        end
        drift = {sum_c[NUM_W], sum_c} - {{2{lastcal_q[NUM_W-1]}}, lastcal_q};
        drift_mag = drift[NUM_W+1] ? (NUM_W+2)'(-drift) : drift;
        // Zero threshold disables drift recalibration
        over_thr = (thr_q != '0) && (drift_mag >= {2'b00, thr_q}); // [RULE5]
        if (manual) begin
            step = man_active && pins.rise && !cal_block; // [RULE13]
        end else begin
            step = (state_q == ST_RUN) && !cal_block; // [RULE10]
        end
    end

    always_comb begin
        state_d = state_q;
        seg_d = seg_q;
        cnt_d = cnt_q;
        num_d = num_q;
        lastcal_d = lastcal_q;
        calreq_d = 1'b0;
        clamped_d = clamped_q;
        seg_start = 1'b0;
        if (!ramp_en || manual) begin
            state_d = ST_IDLE; // [RULE1] [RULE2]
        end
        if (start_q && ramp_en) begin
            num_d = stnum_q;
            seg_d = 1'b0;
            cnt_d = '0;
            clamped_d = 1'b0;
            if (!manual) begin
                state_d = ST_RUN; // [RULE2]
                if (trig_cal) begin
                    calreq_d = 1'b1; // [RULE6]
                    lastcal_d = stnum_q;
                end
            end
        end else if (step) begin
            num_d = sum_c[NUM_W-1:0]; // [RULE3]
            clamped_d = sum_clamped;
            if (manual) begin
                seg_start = 1'b1;
            end else if (cnt_q == len_sel) begin
                // Length 0 still spends one cycle in the segment
                seg_d = ~seg_q; // [RULE4] [RULE10]
                cnt_d = '0;
                seg_start = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1; // [RULE4]
            end
            if ((seg_start && trig_cal) || over_thr) begin
                calreq_d = 1'b1; // [RULE5] [RULE6]
                lastcal_d = sum_c[NUM_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            seg_q <= 1'b0;
            cnt_q <= '0;
            num_q <= NUM_W'(ramp_pkg::NUM_RESET);
            lastcal_q <= NUM_W'(ramp_pkg::NUM_RESET);
            calreq_q <= 1'b0;
            clamped_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seg_q <= seg_d;
            cnt_q <= cnt_d;
            num_q <= num_d;
            lastcal_q <= lastcal_d;
            calreq_q <= calreq_d;
            clamped_q <= clamped_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = hresetn | 1'b1;
    assign hresp = ramp_pkg::HRESP_OKAY;
    assign cal_request = calreq_q;
    assign frac_numerator = num_q;
endmodule : frequency_ramp_generator
`default_nettype wire

//--- logic/ramp_pkg.sv
package ramp_pkg;
    localparam int INC_W = 30;
    localparam int LEN_W = 16;
    localparam int NUM_W = 34;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INC0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INC1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LEN0 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LEN1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_THR_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_THR_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LIML_LO = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_LIML_HI = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_LIMH_LO = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_LIMH_HI = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STNUM_LO = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_STNUM_HI = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_NUM_LO = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_NUM_HI = 8'h3C;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MANUAL_BIT = 1;
    localparam int CTRL_TRIGCAL_BIT = 2;
    localparam int CTRL_START_BIT = 8;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_SEG_BIT = 1;
    localparam int ST_CAL_BIT = 2;
    localparam int ST_CLAMP_BIT = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [INC_W-1:0] INC_RESET = 30'h00000000;
    localparam logic [LEN_W-1:0] LEN_RESET = 16'h0000;
    localparam logic [NUM_W-1:0] THR_RESET = 34'h000000000;
    localparam logic [NUM_W-1:0] LIML_RESET = 34'h200000000;
    localparam logic [NUM_W-1:0] LIMH_RESET = 34'h1FFFFFFFF;
    localparam logic [NUM_W-1:0] NUM_RESET = 34'h000000000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : ramp_pkg

//--- logic/ramp_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ramp_pin_if;
    logic rise;
    logic dir;
    modport src(output rise, output dir);
    modport dst(input rise, input dir);
endinterface : ramp_pin_if
`default_nettype wire

//--- logic/ramp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_pin_sync (
    input wire logic hclk, // Phase detector clock
    input wire logic hresetn, // Async reset, active low
    input wire logic ramp_clock_pin, // Raw ramp clock pin
    input wire logic ramp_direction_pin, // Raw direction pin
    ramp_pin_if.src pins // Synchronised edge and level
);
    logic clk_s1_q, clk_s2_q, clk_s3_q, dir_s1_q, dir_s2_q, rise_q;
    logic clk_s1_d, clk_s2_d, clk_s3_d, dir_s1_d, dir_s2_d, rise_d;

    always_comb begin
        clk_s1_d = ramp_clock_pin; // [RULE12]
        clk_s2_d = clk_s1_q;
        clk_s3_d = clk_s2_q;
        dir_s1_d = ramp_direction_pin;
        dir_s2_d = dir_s1_q;
        // Edge taken from second and third stage only
        rise_d = clk_s2_q & ~clk_s3_q; // [RULE12]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dir_s1_q <= 1'b0;
            dir_s2_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            clk_s1_q <= clk_s1_d;
            clk_s2_q <= clk_s2_d;
            clk_s3_q <= clk_s3_d;
            dir_s1_q <= dir_s1_d;
            dir_s2_q <= dir_s2_d;
            rise_q <= rise_d;
        end
    end

    // Direction is delayed one stage less than the edge, two register stages against three
    assign pins.rise = rise_q;
    assign pins.dir = dir_s2_q;
endmodule : ramp_pin_sync
`default_nettype wire

//--- testbench/ramp_props.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_props #(
    parameter int NUM_W = 34
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic ramp_clock_pin, // Pin clock
    input wire logic ramp_direction_pin, // Pin direction
    input wire logic cal_busy, // Calibration running
    input wire logic cal_request, // Calibration request
    input wire logic [NUM_W-1:0] frac_numerator // Numerator
);
    logic wv_q, pin_q, en_q, man_q, trig_q;
    logic [7:0] wa_q;
    logic [2:0] cw_q;
    logic [3:0] rc_q;
    logic [29:0] i0_q, i1_q;
    wire logic cw = wv_q && wa_q == ramp_pkg::OFS_CTRL;
    // Control writes open a short window where loads and mode changes may land
    wire logic quiet = !cw && cw_q == 3'h0;
    wire logic man = en_q && man_q && quiet;
    wire logic [NUM_W-1:0] x0 = {{(NUM_W-30){i0_q[29]}}, i0_q};
    wire logic [NUM_W-1:0] x1 = {{(NUM_W-30){i1_q[29]}}, i1_q};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_q <= 1'b0;
            pin_q <= 1'b0;
            {trig_q, man_q, en_q} <= 3'h0;
            wa_q <= 8'h00;
            cw_q <= 3'h0;
            rc_q <= 4'hF;
            i0_q <= 30'h0;
            i1_q <= 30'h0;
        end else begin
            wv_q <= hsel && hready && htrans == ramp_pkg::HTRANS_NONSEQ && hwrite;
            wa_q <= haddr[7:0];
            cw_q <= {cw_q[1:0], cw};
            pin_q <= ramp_clock_pin;
            rc_q <= (ramp_clock_pin && !pin_q) ? 4'h0 : rc_q + {3'h0, rc_q != 4'hF};
            if (cw) {trig_q, man_q, en_q} <= hwdata[2:0];
            if (wv_q && wa_q == ramp_pkg::OFS_INC0) i0_q <= hwdata[29:0];
            if (wv_q && wa_q == ramp_pkg::OFS_INC1) i1_q <= hwdata[29:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_edge;
        man && $rose(ramp_clock_pin);
    endsequence
    sequence s_hold;
        $stable(frac_numerator) [*2];
    endsequence
    property p_off;
        quiet && !en_q |=> $stable(frac_numerator);
    endproperty
    property p_man;
        man && rc_q > 4'h9 |=> $stable(frac_numerator);
    endproperty
    property p_sync;
        s_edge |=> s_hold;
    endproperty
    property p_accept;
        s_edge ##0 (!cal_busy && !cal_request) |-> ##[2:7] $changed(frac_numerator);
    endproperty
    property p_dir;
        man && $changed(frac_numerator) |->
            frac_numerator - $past(frac_numerator) == (ramp_direction_pin ? x1 : x0);
    endproperty
    property p_pause;
        quiet && (cal_busy || cal_request) |=> $stable(frac_numerator);
    endproperty
    property p_pulse;
        cal_request |=> !cal_request;
    endproperty
    property p_tstart;
        cw && hwdata[8] && hwdata[0] && !hwdata[1] && hwdata[2] |-> ##[1:3] cal_request;
    endproperty
    property p_trig;
        man && trig_q && $changed(frac_numerator) |-> ##[0:2] cal_request;
    endproperty
    a_off: assert property (p_off)
        else $error("numerator moved while disabled");
    a_man: assert property (p_man)
        else $error("manual numerator moved without pin edge");
    a_sync: assert property (p_sync)
        else $error("pin edge acted on before synchronising");
    a_accept: assert property (p_accept)
        else $error("accepted pin edge gave no step");
    a_dir: assert property (p_dir)
        else $error("manual step size wrong for direction");
    a_pause: assert property (p_pause)
        else $error("numerator moved during calibration");
    a_pulse: assert property (p_pulse)
        else $error("calibration request longer than one cycle");
    a_tstart: assert property (p_tstart)
        else $error("no calibration at ramp start");
    a_trig: assert property (p_trig)
        else $error("no calibration after manual step");
endmodule : ramp_props
bind frequency_ramp_generator ramp_props #(.NUM_W(NUM_W)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .ramp_clock_pin(ramp_clock_pin),
    .ramp_direction_pin(ramp_direction_pin), .cal_busy(cal_busy), .cal_request(cal_request),
    .frac_numerator(frac_numerator));
`default_nettype wire

//--- testbench/ramp_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_ctrl_model #(
    parameter int CAL_CYC = 40
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic cal_request, // Calibration request
    output logic ramp_clock_pin, // Pin clock
    output logic ramp_direction_pin, // Pin direction
    output logic cal_busy // Calibration running
);
    logic [7:0] cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_q <= 8'h00;
        else if (cal_request) cnt_q <= 8'(CAL_CYC);
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
    assign cal_busy = cnt_q != 8'h00;
    initial begin
        ramp_clock_pin = 1'b0;
        ramp_direction_pin = 1'b0;
    end
    // Direction settles a pin period and a half before the rise and holds past it
    // Two edges per call break the rate on purpose, for the dropped-edge case
    task automatic step(input logic dir, input int edges);
        ramp_direction_pin = dir;
        #125;
        repeat (edges) begin
            #62.5 ramp_clock_pin = 1'b1;
            #62.5 ramp_clock_pin = 1'b0;
        end
        #3800; // Edge rate at or below 250 kHz
    endtask : step
endmodule : ramp_ctrl_model
`default_nettype wire

//--- testbench/frequency_ramp_generator_tb.sv
`timescale 1ns/100ps
`default_nettype none
module frequency_ramp_generator_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, dir, busy, creq, seg;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [33:0] num, e;
    int err_count, checks_done, c;
    frequency_ramp_generator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ramp_clock_pin(pin),
        .ramp_direction_pin(dir), .cal_busy(busy), .cal_request(creq), .frac_numerator(num));
    ramp_ctrl_model ctl (.hclk(hclk), .hresetn(hresetn), .cal_request(creq),
        .ramp_clock_pin(pin), .ramp_direction_pin(dir), .cal_busy(busy));
    // hclk stands for the phase detector, faster than advised for ramping
    // Denominator, lock-detect delay and calibration clock live outside the block
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic results;
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tick
    task automatic wait_rdy;
        int n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                results();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= ramp_pkg::HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rv = hrdata;
        chk({33'h0, hresp}, {33'h0, ramp_pkg::HRESP_OKAY});
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic wr2(input logic [7:0] a, input logic [33:0] d);
        wr(a, d[31:0]);
        wr(a + 8'h04, {30'h0, d[33:32]});
    endtask : wr2
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk({2'h0, rv}, {2'h0, x});
    endtask : rd
    task automatic setup(input logic [33:0] st, input logic [29:0] i0, input logic [29:0] i1,
                         input logic [15:0] l0, input logic [15:0] l1, input logic [31:0] ctl_v);
        wr2(ramp_pkg::OFS_STNUM_LO, st);
        wr(ramp_pkg::OFS_INC0, {2'h0, i0});
        wr(ramp_pkg::OFS_INC1, {2'h0, i1});
        wr(ramp_pkg::OFS_LEN0, {16'h0, l0});
        wr(ramp_pkg::OFS_LEN1, {16'h0, l1});
        wr(ramp_pkg::OFS_CTRL, ctl_v);
    endtask : setup
    // Checks the numerator at the next cycle where the flag or value shows up
    task automatic await(input logic cal, input logic [33:0] x);
        int n = 0;
        #1;
        while ((cal ? creq !== 1'b1 : num !== x) && n < 3000) begin
            n++;
            tick(1);
        end
        if (n == 3000) begin
            err_count++;
            results();
        end
        chk(num, x);
        tick(1);
    endtask : await
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 16; a++) begin
            rd(8'(a * 4), a == 8 ? 32'h2 : a == 9 ? 32'hFFFFFFFF : a == 10 ? 32'h1 : 32'h0);
        end
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        setup(34'h64, 30'h5, 30'h5, 16'h0, 16'h0, 32'h100);
        tick(20);
        chk(num, 34'h0);
        setup(34'h3E8, 30'h3, 30'h3FFFFFFE, 16'h2, 16'h1, 32'h101);
        await(1'b0, 34'h3E8);
        e = 34'h3E8;
        seg = 1'b0;
        c = 0;
        for (int k = 0; k < 12; k++) begin
            e += seg ? 34'h3FFFFFFFE : 34'h3;
            c++;
            if (c == (seg ? 2 : 3)) begin
                seg = !seg;
                c = 0;
            end
            chk(num, e);
            tick(1);
        end
        wr(ramp_pkg::OFS_CTRL, 32'h0);
        wr2(ramp_pkg::OFS_LIMH_LO, 34'h3F2);
        setup(34'h3E8, 30'h4, 30'h4, 16'h64, 16'h64, 32'h101);
        tick(20);
        chk(num, 34'h3F2);
        rd(ramp_pkg::OFS_STATUS, 32'h9);
        wr(ramp_pkg::OFS_CTRL, 32'h0);
        wr2(ramp_pkg::OFS_LIMH_LO, 34'h1FFFFFFFF);
        wr2(ramp_pkg::OFS_LIML_LO, 34'h3FFFFFFFB);
        setup(34'h0, 30'h3FFFFFFD, 30'h3FFFFFFD, 16'h64, 16'h64, 32'h101);
        tick(20);
        rd(ramp_pkg::OFS_NUM_LO, 32'hFFFFFFFB);
        rd(ramp_pkg::OFS_NUM_HI, 32'h3);
        wr(ramp_pkg::OFS_CTRL, 32'h0);
        wr2(ramp_pkg::OFS_THR_LO, 34'hA);
        setup(34'h0, 30'h3, 30'h3, 16'h3E8, 16'h3E8, 32'h101);
        await(1'b1, 34'hC);
        await(1'b1, 34'h18);
        wr(ramp_pkg::OFS_CTRL, 32'h0);
        wr2(ramp_pkg::OFS_THR_LO, 34'h0);
        setup(34'h1F4, 30'h1, 30'h1, 16'h1, 16'h1, 32'h105);
        await(1'b1, 34'h1F4);
        await(1'b1, 34'h1F6);
        wr(ramp_pkg::OFS_CTRL, 32'h0);
        setup(34'h3E8, 30'h7, 30'h3FFFFFFC, 16'h0, 16'h0, 32'h103);
        ctl.step(1'b0, 1);
        chk(num, 34'h3EF);
        ctl.step(1'b1, 1);
        chk(num, 34'h3EB);
        wr(ramp_pkg::OFS_CTRL, 32'h107);
        ctl.step(1'b0, 2);
        chk(num, 34'h3EF);
        wr(ramp_pkg::OFS_CTRL, 32'h2);
        ctl.step(1'b0, 1);
        chk(num, 34'h3EF);
        results();
    end
endmodule : frequency_ramp_generator_tb
`default_nettype wire
